// File: shared/mmr_pkg.sv
// Constants, types and tables for the mixer monitor routing control block
// Function
// RQ1: Normally route main buses to tape and mono outs
// RQ2: Battery hold plus return move toggles loopback source
// RQ3: Flash selected return LED while loopback active
// RQ4: Critical battery while recording closes file, blocks recorder
// RQ5: Battery press and release shows both supply voltages
// RQ6: Power LED green, yellow at warning, flashing red low; yellow is shown on internal power only, external warning stays green
// RQ7: Five external threshold sets, set one default
// RQ8: Slate short move toggles latch, long hold momentary
// RQ9: Slate/tone LED lit while either is latched
// RQ10: Active slate mutes program, feeds all outputs
// RQ11: Optional one second pre-tone, optional slate disable
// RQ12: Tone while held right, two second hold latches
// RQ13: Tone to main and direct outs, headphones attenuated
// RQ14: Battery press during tone toggles left level cycling
// RQ15: Talk-back keeps slate off outputs, headphone right only
// RQ16: Talk-back: large jack program, small jack menu source
// RQ17: Four small jack sources selected by talk-back setting
// RQ18: Talk-back is menu entry at left meter position zero
// RQ19: Slate held plus encoder sets small jack gain
// RQ20: Battery plus slate held gives all-call unless disabled
// RQ21: Hold timed from move; short toggles, long momentary
package mmr_pkg;
    // Clock rate and gesture times
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned SLATE_HOLD_MS = 1000;
    localparam int unsigned TONE_HOLD_MS  = 2000;
    localparam int unsigned PRETONE_MS    = 1000;
    localparam int unsigned FLASH_MS      = 250;
    localparam int unsigned CYCLE_MS      = 1000;
    localparam int unsigned SHOW_MS       = 2000;
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
    localparam int unsigned SLATE_HOLD_CYC = SLATE_HOLD_MS * CYC_PER_MS;
    localparam int unsigned TONE_HOLD_CYC  = TONE_HOLD_MS * CYC_PER_MS;
    localparam int unsigned PRETONE_CYC    = PRETONE_MS * CYC_PER_MS;
    localparam int unsigned FLASH_CYC      = FLASH_MS * CYC_PER_MS;
    localparam int unsigned CYCLE_CYC      = CYCLE_MS * CYC_PER_MS;
    localparam int unsigned SHOW_CYC       = SHOW_MS * CYC_PER_MS;
    // Tone defaults, 1 kHz at 0 dBu; level in dBu
    localparam int unsigned TONE_FREQ_HZ = 1000;
    localparam int          TONE_LVL_DBU = 0;
    localparam int          CYCLE_CUT_DB = -20;
    // Setup menu position of talk-back on the left meter
    localparam logic [3:0] TB_MENU_POS = 4'h0;
    // Synchronised panel input indices
    localparam int unsigned I_BAT = 0;
    localparam int unsigned I_RA  = 1;
    localparam int unsigned I_RB  = 2;
    localparam int unsigned I_SL  = 3;
    localparam int unsigned I_TN  = 4;
    localparam int unsigned I_UP  = 5;
    localparam int unsigned I_DN  = 6;
    localparam int unsigned N_IN  = 7;
    // Voltages in tenths of a volt; internal points are plain defaults
    localparam logic [7:0] INT_WARN = 8'h2c;
    localparam logic [7:0] INT_LOW  = 8'h28;
    localparam logic [7:0] INT_CRIT = 8'h24;
    localparam logic [2:0] EXT_SET_DFLT = 3'h1;
    localparam logic [2:0] EXT_SET_MAX  = 3'h5;
    localparam logic [7:0] EXT_HI [0:4] = '{8'h82, 8'haa, 8'h8c, 8'haa, 8'ha3};
    localparam logic [7:0] EXT_WN [0:4] = '{8'h73, 8'h73, 8'h72, 8'h73, 8'h87};
    localparam logic [7:0] EXT_LO [0:4] = '{8'h6e, 8'h6e, 8'h64, 8'h32, 8'h7d};
    localparam logic [5:0] TB_GAIN_RST = 6'h20;
    localparam logic [5:0] TB_GAIN_MAX = 6'h3f;
    // Tape and mono mic source
    typedef enum logic [1:0] {
        LB_NORM = 2'b00,
        LB_A    = 2'b01,
        LB_B    = 2'b10
    } mmr_lb_e;
    // Power LED state
    typedef enum logic [1:0] {
        PL_GREEN  = 2'b00,
        PL_YELLOW = 2'b01,
        PL_RED    = 2'b10
    } mmr_pled_e;
    // Talk-back small jack source
    typedef enum logic [1:0] {
        TB_OFF   = 2'b00,
        TB_SLATE = 2'b01,
        TB_LEFT  = 2'b10,
        TB_CH1   = 2'b11
    } mmr_tb_e;
endpackage : mmr_pkg

// File: rtl/mmr_ctrl.sv
// Front panel gesture decode, routing and indicator control
`timescale 1ns/10ps
module mmr_ctrl #(
    parameter int unsigned SLATE_HOLD_CYC = mmr_pkg::SLATE_HOLD_CYC,
    parameter int unsigned TONE_HOLD_CYC  = mmr_pkg::TONE_HOLD_CYC,
    parameter int unsigned PRETONE_CYC    = mmr_pkg::PRETONE_CYC,
    parameter int unsigned FLASH_CYC      = mmr_pkg::FLASH_CYC,
    parameter int unsigned CYCLE_CYC      = mmr_pkg::CYCLE_CYC,
    parameter int unsigned SHOW_CYC       = mmr_pkg::SHOW_CYC,
    parameter int unsigned CW             = 29
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            bat_btn,         // Battery check, pin
    input  wire logic            return_sel_a,    // Return selector left, pin
    input  wire logic            return_sel_b,    // Return selector right, pin
    input  wire logic            slate_sw,        // Slate/tone left, pin
    input  wire logic            tone_sw,         // Slate/tone right, pin
    input  wire logic            enc_up,          // Headphone encoder step up, pin
    input  wire logic            enc_dn,          // Headphone encoder step down, pin
    input  wire logic            rec_active,      // Recorder recording, same clock
    input  wire logic            pwr_ext,         // Source switch external, same clock
    input  wire logic [7:0]      int_volt,        // Internal volts x10
    input  wire logic [7:0]      ext_volt,        // External volts x10
    input  wire logic [2:0]      ext_set,         // Threshold set 1..5
    input  wire logic [1:0]      tb_sel,          // Talk-back option
    input  wire logic            pretone_en,      // Tone before slate
    input  wire logic            slate_dis,       // Slate disabled
    output mmr_pkg::mmr_lb_e     tape_src,        // Tape and mono mic source
    output logic                 led_rtn_a_flash,
    output logic                 led_rtn_b_flash,
    output logic                 meter_show_volts,
    output logic                 rec_close,
    output logic                 rec_blocked,
    output mmr_pkg::mmr_pled_e   pwr_led,
    output logic                 pwr_led_on,      // Flash phase gate
    output logic [7:0]           ext_hi_pt,
    output logic [7:0]           ext_wn_pt,
    output logic [7:0]           ext_lo_pt,
    output logic                 led_slate_tone,
    output logic                 prog_mute,
    output logic                 slate_to_outs,
    output logic                 pretone_on,
    output logic                 slate_to_hp_r,
    output logic                 tone_on,
    output logic                 hp_atten,
    output logic                 left_cut,
    output mmr_pkg::mmr_tb_e     hp_small_src,
    output logic [5:0]           tb_gain
);
    localparam int unsigned NI = mmr_pkg::N_IN;
    // Counters must hold every hold time
    if (CW > 31 || SLATE_HOLD_CYC < 1 || TONE_HOLD_CYC < 1 || PRETONE_CYC < 1
        || FLASH_CYC < 1 || CYCLE_CYC < 1 || SHOW_CYC < 1
        || (64'(TONE_HOLD_CYC) >> CW) != 0 || (64'(SHOW_CYC) >> CW) != 0
        || (64'(SLATE_HOLD_CYC) >> CW) != 0 || (64'(PRETONE_CYC) >> CW) != 0
        || (64'(CYCLE_CYC) >> CW) != 0 || (64'(FLASH_CYC) >> CW) != 0) begin : g_chk
        $error("mmr_ctrl: counter width too small for timing parameters");
    end
    localparam logic [CW-1:0] SL_H = CW'(SLATE_HOLD_CYC);
    localparam logic [CW-1:0] TN_H = CW'(TONE_HOLD_CYC);
    localparam logic [CW-1:0] PT_N = CW'(PRETONE_CYC);
    localparam logic [CW-1:0] FL_N = CW'(FLASH_CYC);
    localparam logic [CW-1:0] CY_N = CW'(CYCLE_CYC);
    localparam logic [CW-1:0] SH_N = CW'(SHOW_CYC);
    // Whole module state
    typedef struct packed {
        logic [NI-1:0]      sy1;       // Sync stage one
        logic [NI-1:0]      sy2;
        logic [NI-1:0]      sy3;
        logic [NI-1:0]      st;        // Debounced panel levels
        mmr_pkg::mmr_lb_e   lb;        // Loopback source
        logic               combo;     // Battery hold used in a combo
        logic               show;
        logic [CW-1:0]      sh_cnt;
        logic               sl_latch;
        logic               sl_used;   // Slate hold used for other gesture
        logic [CW-1:0]      sl_cnt;
        logic               tn_latch;
        logic [CW-1:0]      tn_cnt;
        logic               all_d;     // Previous slate-to-all
        logic               pre_run;
        logic [CW-1:0]      pt_cnt;
        logic               flash;
        logic [CW-1:0]      fl_cnt;
        logic               cyc_on;
        logic               cyc_cut;
        logic [CW-1:0]      cy_cnt;
        logic               rec_blk;
        logic               rec_cls;
        logic               ext_d;
        logic               low_seen;
        mmr_pkg::mmr_pled_e pled;
        logic [5:0]         gain;
        logic [7:0]         hi_pt;
        logic [7:0]         wn_pt;
        logic [7:0]         lo_pt;
    } mmr_state_s;
    mmr_state_s s_reg;
    mmr_state_s s_next;
    logic [NI-1:0] st_new;    // Debounced levels this edge
    logic [NI-1:0] rise;
    logic [NI-1:0] fall;
    logic          talkback;
    logic          all_call;
    logic          slate_act;
    logic          slate_all;
    logic          tone_act;
    logic          crit;
    logic [2:0]    set_idx;
    logic [7:0]    src_v;
    logic [7:0]    src_wn;
    logic [7:0]    src_lo;
    // A change counts once stages two and three agree
    assign st_new = (~(s_reg.sy2 ^ s_reg.sy3) & s_reg.sy3)
                  | ((s_reg.sy2 ^ s_reg.sy3) & s_reg.st);
    assign rise   = st_new & ~s_reg.st;
    assign fall   = ~st_new & s_reg.st;
    // Mode terms seen by routing and gestures
    assign talkback  = (tb_sel != mmr_pkg::TB_OFF);             // RQ18
    assign all_call  = talkback & s_reg.st[mmr_pkg::I_BAT]
                     & s_reg.st[mmr_pkg::I_SL] & ~slate_dis;   // RQ20
    assign slate_act = (s_reg.sl_latch | s_reg.st[mmr_pkg::I_SL]) & ~slate_dis; // RQ11
    assign slate_all = slate_act & (~talkback | all_call);     // RQ10 RQ15 RQ20
    assign tone_act  = s_reg.tn_latch | s_reg.st[mmr_pkg::I_TN];
    // Critical battery only matters on internal power
    assign crit = ~pwr_ext & (int_volt <= mmr_pkg::INT_CRIT);
    // Out-of-range setting falls back to the factory set
    assign set_idx = (ext_set >= 3'h1 && ext_set <= mmr_pkg::EXT_SET_MAX)
                   ? ext_set - 3'h1 : mmr_pkg::EXT_SET_DFLT - 3'h1;  // RQ7
    assign src_v  = pwr_ext ? ext_volt : int_volt;
    assign src_wn = pwr_ext ? mmr_pkg::EXT_WN[set_idx] : mmr_pkg::INT_WARN;
    assign src_lo = pwr_ext ? mmr_pkg::EXT_LO[set_idx] : mmr_pkg::INT_LOW;

    // Next-state logic for the whole block
    always_comb begin
        s_next     = s_reg;
        // Three-stage synchroniser on panel pins
        s_next.sy1 = {enc_dn, enc_up, tone_sw, slate_sw, return_sel_b,
                      return_sel_a, bat_btn};
        s_next.sy2 = s_reg.sy1;
        s_next.sy3 = s_reg.sy2;
        s_next.st  = st_new;

        // Battery button combos: loopback toggle
        if (rise[mmr_pkg::I_BAT]) begin
            s_next.combo = 1'b0;
        end
        if (s_reg.st[mmr_pkg::I_BAT] && rise[mmr_pkg::I_RA]) begin
            s_next.combo = 1'b1;
            s_next.lb    = (s_reg.lb == mmr_pkg::LB_A) ? mmr_pkg::LB_NORM
                                                       : mmr_pkg::LB_A;  // RQ2
        end else if (s_reg.st[mmr_pkg::I_BAT] && rise[mmr_pkg::I_RB]) begin
            s_next.combo = 1'b1;
            s_next.lb    = (s_reg.lb == mmr_pkg::LB_B) ? mmr_pkg::LB_NORM
                                                       : mmr_pkg::LB_B;  // RQ2
        end
        if (s_reg.st[mmr_pkg::I_BAT] && s_reg.st[mmr_pkg::I_SL]) begin
            s_next.combo = 1'b1;
        end

        // Tone owns the battery press for level cycling
        if (rise[mmr_pkg::I_BAT] && tone_act) begin
            s_next.combo  = 1'b1;
            s_next.cyc_on = ~s_reg.cyc_on;   // RQ14
            s_next.cy_cnt = '0;
            s_next.cyc_cut = 1'b0;
        end
        if (!tone_act) begin
            s_next.cyc_on  = 1'b0;           // RQ14
            s_next.cyc_cut = 1'b0;
        end else if (s_reg.cyc_on) begin
            if (s_reg.cy_cnt >= CY_N - 1'b1) begin
                s_next.cy_cnt  = '0;
                s_next.cyc_cut = ~s_reg.cyc_cut;
            end else begin
                s_next.cy_cnt = s_reg.cy_cnt + 1'b1;
            end
        end

        // Clean press and release shows supply voltages
        if (fall[mmr_pkg::I_BAT] && !s_reg.combo) begin
            s_next.show   = 1'b1;            // RQ5
            s_next.sh_cnt = '0;
        end else if (s_reg.show) begin
            if (s_reg.sh_cnt >= SH_N - 1'b1) begin
                s_next.show = 1'b0;
            end else begin
                s_next.sh_cnt = s_reg.sh_cnt + 1'b1;
            end
        end

        // Slate hold timer runs from the move
        if (rise[mmr_pkg::I_SL]) begin
            s_next.sl_cnt  = '0;             // RQ21
            s_next.sl_used = s_reg.st[mmr_pkg::I_BAT];
        end else if (s_reg.st[mmr_pkg::I_SL]) begin
            if (s_reg.sl_cnt < SL_H) begin
                s_next.sl_cnt = s_reg.sl_cnt + 1'b1;
            end
            if (s_reg.st[mmr_pkg::I_BAT]) begin
                s_next.sl_used = 1'b1;
            end
        end
        // Short move toggles the latch; long hold was momentary
        if (fall[mmr_pkg::I_SL] && !s_reg.sl_used && s_reg.sl_cnt < SL_H) begin
            s_next.sl_latch = ~s_reg.sl_latch;   // RQ8 RQ21
        end
        if (slate_dis) begin
            s_next.sl_latch = 1'b0;              // RQ11
        end

        // Small jack gain while slate held in talk-back
        if (talkback && s_reg.st[mmr_pkg::I_SL]) begin
            if (rise[mmr_pkg::I_UP]) begin
                s_next.sl_used = 1'b1;
                if (s_reg.gain != mmr_pkg::TB_GAIN_MAX) begin
                    s_next.gain = s_reg.gain + 1'b1;   // RQ19
                end
            end else if (rise[mmr_pkg::I_DN]) begin
                s_next.sl_used = 1'b1;
                if (s_reg.gain != 6'h00) begin
                    s_next.gain = s_reg.gain - 1'b1;   // RQ19
                end
            end
        end

        // Tone: momentary while held, latches at the long hold
        if (rise[mmr_pkg::I_TN]) begin
            s_next.tn_cnt = '0;
        end else if (s_reg.st[mmr_pkg::I_TN] && s_reg.tn_cnt < TN_H) begin
            s_next.tn_cnt = s_reg.tn_cnt + 1'b1;
            if (s_reg.tn_cnt == TN_H - 1'b1) begin
                s_next.tn_latch = 1'b1;          // RQ12
            end
        end
        // A short move while latched turns tone off
        if (fall[mmr_pkg::I_TN] && s_reg.tn_cnt < TN_H - 1'b1) begin
            s_next.tn_latch = 1'b0;
        end

        // Pre-tone ahead of slate going to the outputs
        s_next.all_d = slate_all;
        if (slate_all && !s_reg.all_d && pretone_en) begin
            s_next.pre_run = 1'b1;               // RQ11
            s_next.pt_cnt  = '0;
        end else if (!slate_all) begin
            s_next.pre_run = 1'b0;
        end else if (s_reg.pre_run) begin
            if (s_reg.pt_cnt >= PT_N - 1'b1) begin
                s_next.pre_run = 1'b0;
            end else begin
                s_next.pt_cnt = s_reg.pt_cnt + 1'b1;
            end
        end

        // Free-running flash phase for LEDs
        if (s_reg.fl_cnt >= FL_N - 1'b1) begin
            s_next.fl_cnt = '0;
            s_next.flash  = ~s_reg.flash;
        end else begin
            s_next.fl_cnt = s_reg.fl_cnt + 1'b1;
        end

        // Critical battery protection of the open file
        s_next.rec_cls = 1'b0;
        s_next.ext_d   = pwr_ext;
        if (pwr_ext && !s_reg.ext_d) begin
            s_next.rec_blk = 1'b0;               // RQ4
        end else if (rec_active && crit && !s_reg.rec_blk) begin
            s_next.rec_cls = 1'b1;               // RQ4
            s_next.rec_blk = 1'b1;
        end

        // Power LED; red stays until power is lost
        if (src_v <= src_lo) begin
            s_next.low_seen = 1'b1;              // RQ6
        end
        if (s_next.low_seen) begin
            s_next.pled = mmr_pkg::PL_RED;
        end else if (src_v <= src_wn && !pwr_ext) begin
            s_next.pled = mmr_pkg::PL_YELLOW;
        end else begin
            s_next.pled = mmr_pkg::PL_GREEN;
        end

        // External meter scale from the chosen set
        s_next.hi_pt = mmr_pkg::EXT_HI[set_idx]; // RQ7
        s_next.wn_pt = mmr_pkg::EXT_WN[set_idx];
        s_next.lo_pt = mmr_pkg::EXT_LO[set_idx];
    end

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg        <= '0;
            s_reg.lb     <= mmr_pkg::LB_NORM;
            s_reg.pled   <= mmr_pkg::PL_GREEN;
            s_reg.gain   <= mmr_pkg::TB_GAIN_RST;
            s_reg.hi_pt  <= mmr_pkg::EXT_HI[0];
            s_reg.wn_pt  <= mmr_pkg::EXT_WN[0];
            s_reg.lo_pt  <= mmr_pkg::EXT_LO[0];
        end else begin
            s_reg <= s_next;
        end
    end

    // Routing and indicator outputs
    assign tape_src         = s_reg.lb;                                   // RQ1
    assign led_rtn_a_flash  = (s_reg.lb == mmr_pkg::LB_A) & s_reg.flash;  // RQ3
    assign led_rtn_b_flash  = (s_reg.lb == mmr_pkg::LB_B) & s_reg.flash;  // RQ3
    assign meter_show_volts = s_reg.show;
    assign rec_close        = s_reg.rec_cls;
    assign rec_blocked      = s_reg.rec_blk;
    assign pwr_led          = s_reg.pled;
    assign pwr_led_on       = (s_reg.pled != mmr_pkg::PL_RED) | s_reg.flash;
    assign ext_hi_pt        = s_reg.hi_pt;
    assign ext_wn_pt        = s_reg.wn_pt;
    assign ext_lo_pt        = s_reg.lo_pt;
    assign led_slate_tone   = s_reg.sl_latch | s_reg.tn_latch;            // RQ9
    assign prog_mute        = slate_all;                                  // RQ10
    assign slate_to_outs    = slate_all & ~s_reg.pre_run & (s_reg.all_d | ~pretone_en); // RQ11
    assign pretone_on       = s_reg.pre_run;
    assign slate_to_hp_r    = slate_act & talkback & ~slate_all;          // RQ15
    assign tone_on          = tone_act;                                   // RQ13
    assign hp_atten         = tone_act;                                   // RQ13
    assign left_cut         = s_reg.cyc_on & s_reg.cyc_cut;               // RQ14
    assign hp_small_src     = mmr_pkg::mmr_tb_e'(tb_sel);                 // RQ16 RQ17
    assign tb_gain          = s_reg.gain;

    // Checks next to the logic
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence bat_clean_release;
        fall[mmr_pkg::I_BAT] && !s_reg.combo;
    endsequence

    sequence show_held;
        meter_show_volts [*8];
    endsequence

    loop_to_a_a: assert property (s_reg.st[mmr_pkg::I_BAT] && rise[mmr_pkg::I_RA]  // RQ2
        && s_reg.lb == mmr_pkg::LB_NORM |=> tape_src == mmr_pkg::LB_A)
        else $error("loopback A not taken");
    loop_hold_a: assert property (!s_reg.st[mmr_pkg::I_BAT] |=> $stable(tape_src)) // RQ1
        else $error("routing moved without battery hold");
    rtn_flash_a: assert property (led_rtn_a_flash |-> tape_src == mmr_pkg::LB_A)  // RQ3
        else $error("return A flash without loopback");
    rec_block_a: assert property (rec_close |-> rec_blocked ##1 !rec_close)        // RQ4
        else $error("file close without block");
    volt_show_a: assert property (bat_clean_release |=> show_held)               // RQ5
        else $error("voltage display not shown");
    red_stick_a: assert property (pwr_led == mmr_pkg::PL_RED |=> pwr_led == mmr_pkg::PL_RED) // RQ6
        else $error("red power LED cleared");
    ext_set4_a: assert property (ext_set == 3'h4 |=> ext_lo_pt == mmr_pkg::EXT_LO[3]) // RQ7
        else $error("set four low point wrong");
    slate_tog_a: assert property (fall[mmr_pkg::I_SL] && !s_reg.sl_used && !slate_dis // RQ8
        && s_reg.sl_cnt < SL_H |=> s_reg.sl_latch != $past(s_reg.sl_latch))
        else $error("short slate move did not toggle");
    tb_excl_a: assert property (talkback && !all_call |-> !slate_to_outs && !prog_mute) // RQ15
        else $error("slate reached outputs in talk-back");
    tone_latch_a: assert property (s_reg.st[mmr_pkg::I_TN] && !fall[mmr_pkg::I_TN] // RQ12
        && s_reg.tn_cnt == TN_H - 1'b1 |=> led_slate_tone)
        else $error("tone hold did not latch");
    cycle_stop_a: assert property (!tone_on |=> !left_cut)                        // RQ14
        else $error("left cycling without tone");
endmodule : mmr_ctrl

// File: sim/mmr_panel.sv
// Front panel model: operator controls as pin levels
`timescale 1ns/10ps
module mmr_panel (
    input  wire logic       clk,
    output logic      [6:0] pins
);
    // All controls at rest
    initial pins = 7'h00;
    // One move, just after an edge
    task automatic move(input int idx, input logic lvl);
        @(posedge clk);
        #1 pins[idx] = lvl;
    endtask : move
endmodule : mmr_panel

// File: sim/tb_top.sv
// Self-checking bench for the panel routing control
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] pins;
    logic rec_active = 1'b0, pwr_ext = 1'b0, pretone_en = 1'b0, slate_dis = 1'b0;
    logic [7:0] int_volt = 8'h50, ext_volt = 8'h80;
    logic [2:0] ext_set = 3'h1;
    logic [1:0] tb_sel = 2'h0;
    mmr_pkg::mmr_lb_e   tape_src;
    mmr_pkg::mmr_pled_e pwr_led;
    mmr_pkg::mmr_tb_e   hp_small_src;
    logic led_rtn_a_flash, led_rtn_b_flash, meter_show_volts, rec_close, rec_blocked;
    logic pwr_led_on, led_slate_tone, prog_mute, slate_to_outs, pretone_on;
    logic slate_to_hp_r, tone_on, hp_atten, left_cut;
    logic [7:0] ext_hi_pt, ext_wn_pt, ext_lo_pt;
    logic [5:0] tb_gain;
    int err_total = 0;
    int cmp_count = 0;
    int n;
    // Threshold sets, tenths of a volt
    int hi_q[$] = '{130, 170, 140, 170, 163};
    int wn_q[$] = '{115, 115, 114, 115, 135};
    int lo_q[$] = '{110, 110, 100, 50, 125};
    always #2.5 clk = ~clk;
    mmr_panel i_mmr_panel (.clk, .pins);
    // Short hold counts keep the run brief
    mmr_ctrl #(.SLATE_HOLD_CYC(20), .TONE_HOLD_CYC(40), .PRETONE_CYC(20),
        .FLASH_CYC(4), .CYCLE_CYC(8), .SHOW_CYC(16)) i_mmr_ctrl (
        .clk, .rst, .bat_btn(pins[0]), .return_sel_a(pins[1]), .return_sel_b(pins[2]),
        .slate_sw(pins[3]), .tone_sw(pins[4]), .enc_up(pins[5]), .enc_dn(pins[6]),
        .rec_active, .pwr_ext, .int_volt, .ext_volt, .ext_set, .tb_sel, .pretone_en,
        .slate_dis, .tape_src, .led_rtn_a_flash, .led_rtn_b_flash, .meter_show_volts,
        .rec_close, .rec_blocked, .pwr_led, .pwr_led_on, .ext_hi_pt, .ext_wn_pt,
        .ext_lo_pt, .led_slate_tone, .prog_mute, .slate_to_outs, .pretone_on,
        .slate_to_hp_r, .tone_on, .hp_atten, .left_cut, .hp_small_src, .tb_gain);
    task automatic stop_test();
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : tick
    // Gesture: pin to level, then let sync settle
    task automatic mv(input int idx, input logic lvl, input int c);
        i_mmr_panel.move(idx, lvl);
        tick(c);
    endtask : mv
    // Hang guard
    initial begin
        #100000;
        err_total++;
        stop_test();
    end
    initial begin
        void'($urandom(9806));
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        chk(tape_src, mmr_pkg::LB_NORM);
        chk(tb_gain, 8'h20);
        for (int i = 0; i < 5; i++) begin
            ext_set = 3'(i + 1);
            tick(2);
            chk(ext_hi_pt, 8'(hi_q[i]));
            chk(ext_wn_pt, 8'(wn_q[i]));
            chk(ext_lo_pt, 8'(lo_q[i]));
        end
        for (int i = 0; i < 4; i++) begin
            tb_sel = 2'(i);
            int_volt = 8'($urandom_range(96, 48));
            tick(1);
            chk(hp_small_src, 8'(i));
            chk(pwr_led, mmr_pkg::PL_GREEN);
        end
        tb_sel = 2'h0;
        // Loopback on A, switch to B, back to normal
        mv(0, 1'b1, 5);
        mv(1, 1'b1, 5);
        chk(tape_src, mmr_pkg::LB_A);
        n = 0;
        while (led_rtn_a_flash !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk(led_rtn_a_flash, 1'b1);
        mv(1, 1'b0, 5);
        mv(2, 1'b1, 5);
        chk(tape_src, mmr_pkg::LB_B);
        n = 0;
        while (led_rtn_b_flash !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk(led_rtn_b_flash, 1'b1);
        mv(2, 1'b0, 5);
        mv(2, 1'b1, 5);
        chk(tape_src, mmr_pkg::LB_NORM);
        mv(2, 1'b0, 1);
        mv(0, 1'b0, 5);
        chk(meter_show_volts, 1'b0);
        mv(0, 1'b1, 5);
        mv(0, 1'b0, 5);
        chk(meter_show_volts, 1'b1);
        // Slate short move latches, second move clears
        mv(3, 1'b1, 5);
        mv(3, 1'b0, 6);
        chk(led_slate_tone, 1'b1);
        chk(prog_mute, 1'b1);
        chk(slate_to_outs, 1'b1);
        mv(3, 1'b1, 5);
        mv(3, 1'b0, 6);
        chk(led_slate_tone, 1'b0);
        // Talk-back, long hold is momentary
        tb_sel = 2'h1;
        mv(3, 1'b1, 6);
        mv(5, 1'b1, 5);
        mv(5, 1'b0, 5);
        chk(tb_gain, 8'h21);
        mv(6, 1'b1, 5);
        mv(6, 1'b0, 8);
        chk(tb_gain, 8'h20);
        chk(slate_to_hp_r, 1'b1);
        chk(slate_to_outs, 1'b0);
        mv(3, 1'b0, 6);
        chk(slate_to_hp_r, 1'b0);
        // All-call with pre-tone, then slate disabled
        pretone_en = 1'b1;
        mv(0, 1'b1, 5);
        mv(3, 1'b1, 5);
        chk(prog_mute, 1'b1);
        chk(pretone_on, 1'b1);
        tick(22);
        chk(slate_to_outs, 1'b1);
        mv(3, 1'b0, 5);
        mv(0, 1'b0, 5);
        slate_dis = 1'b1;
        tb_sel = 2'h0;
        mv(3, 1'b1, 5);
        chk(prog_mute, 1'b0);
        mv(3, 1'b0, 5);
        slate_dis = 1'b0;
        // Tone held past latch point
        mv(4, 1'b1, 6);
        chk(hp_atten, 1'b1);
        tick(45);
        mv(4, 1'b0, 6);
        chk(tone_on, 1'b1);
        chk(led_slate_tone, 1'b1);
        mv(0, 1'b1, 5);
        mv(0, 1'b0, 5);
        n = 0;
        while (left_cut !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk(left_cut, 1'b1);
        mv(4, 1'b1, 5);
        mv(4, 1'b0, 6);
        chk(tone_on, 1'b0);
        chk(left_cut, 1'b0);
        // Critical battery while recording
        rec_active = 1'b1;
        int_volt = 8'h20;
        n = 0;
        while (rec_close !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk(rec_close, 1'b1);
        chk(rec_blocked, 1'b1);
        chk(pwr_led, mmr_pkg::PL_RED);
        n = 0;
        while (pwr_led_on !== 1'b0 && n < 20) begin
            tick(1);
            n++;
        end
        chk(pwr_led_on, 1'b0);
        ext_volt = 8'($urandom_range(180, 100));
        pwr_ext = 1'b1;
        tick(2);
        chk(rec_blocked, 1'b0);
        chk(pwr_led, mmr_pkg::PL_RED);
        stop_test();
    end
endmodule : tb_top
